// [design/leb_counter.sv]
// leading-edge blanking down counter, restarted by a trigger
`timescale 1ns/1ps
module leb_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [15:0] period_i,
  output logic active_o
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // restart wins over counting down
  always_comb begin
    cnt_d = cnt_q;
    if (start_i) begin
      cnt_d = period_i;
    end else if (cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign active_o = (cnt_q != 16'h0000);
endmodule

// [design/leb_pkg.sv]
// types shared by the blanking unit files
package leb_pkg;
  typedef logic [15:0] reg16_t;
  typedef enum logic [1:0] {
    WB_IDLE = 2'b01,
    WB_ACK = 2'b10
  } wb_state_t;
endpackage

// [design/leb_regs.svh]
// register offsets, field positions, reset values and the state condition count for the blanking unit
`ifndef LEB_REGS_SVH
`define LEB_REGS_SVH

// byte offsets on the wishbone bus
`define LEB_CTRL_OFS 4'h0
`define LEB_AUX_OFS 4'h4
`define LEB_PERIOD_OFS 4'h8
`define LEB_STATUS_OFS 4'hC

// blanking control field positions
`define LEB_HRISE_BIT 15
`define LEB_HFALL_BIT 14
`define LEB_LRISE_BIT 13
`define LEB_LFALL_BIT 12
`define LEB_FLT_BIT 11
`define LEB_CL_BIT 10
`define LEB_SIGH_BIT 5
`define LEB_SIGL_BIT 4
`define LEB_HH_BIT 3
`define LEB_HL_BIT 2
`define LEB_LH_BIT 1
`define LEB_LL_BIT 0

// writable bits of the control register; bits 9..6 have no storage
`define LEB_CTRL_MASK 16'hFC3F
`define LEB_CTRL_RST 16'h0000
`define LEB_AUX_RST 16'h0000
`define LEB_PERIOD_RST 16'h0000

// blanking source select field in the aux register
`define LEB_SEL_LSB 8
`define LEB_SEL_W 4

// state blanking condition count
`define LEB_NCOND 6

`endif

// [design/pwm_fault_limit_blanking.sv]
// pwm channel blanking unit: leading-edge and state blanking of fault and current-limit inputs
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "leb_regs.svh"

// Operation
// - fault edge blank enable gates leading-edge blanking of fault
// - limit edge blank enable gates leading-edge blanking of limit
// - control bits nine to six read zero
// - blank while selected signal high
// - blank while selected signal low
// - blank while high-side output high
// - blank while high-side output low
// - blank while low-side output high
// - blank while low-side output low
// - source select chooses the blanking signal
// - enabled pwm edges restart edge counter
module pwm_fault_limit_blanking
  import leb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pwm_high_side_out_i,
  input wire logic pwm_low_side_out_i,
  input wire logic [15:0] blank_src_i,
  input wire logic fault_i,
  input wire logic climit_i,
  output logic fault_o,
  output logic climit_o
);

  // ************************************
  // pin synchronisers
  // ************************************
  logic hs_s;
  logic ls_s;
  logic flt_s;
  logic cl_s;
  logic [15:0] src_s;

  sync2 u_sync_hs (.clk_i(clk_i), .rst_i(rst_i), .d_i(pwm_high_side_out_i), .q_o(hs_s));
  sync2 u_sync_ls (.clk_i(clk_i), .rst_i(rst_i), .d_i(pwm_low_side_out_i), .q_o(ls_s));
  sync2 u_sync_flt (.clk_i(clk_i), .rst_i(rst_i), .d_i(fault_i), .q_o(flt_s));
  sync2 u_sync_cl (.clk_i(clk_i), .rst_i(rst_i), .d_i(climit_i), .q_o(cl_s));

  // one synchroniser per blanking source line
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_src
      sync2 u_sync_src (.clk_i(clk_i), .rst_i(rst_i), .d_i(blank_src_i[gi]), .q_o(src_s[gi]));
    end
  endgenerate

  // ************************************
  // wishbone slave and registers
  // ************************************
  wb_state_t wb_state_q;
  wb_state_t wb_state_d;
  reg16_t ctrl_q;
  reg16_t ctrl_d;
  reg16_t aux_q;
  reg16_t aux_d;
  reg16_t period_q;
  reg16_t period_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic ack_q;
  logic ack_d;
  logic [1:0] prot_s;
  logic wr_go;

  // byte lanes 0 and 1 carry the 16-bit registers
  function automatic reg16_t lane_merge(input reg16_t old, input logic [31:0] dat, input logic [3:0] sel);
    reg16_t r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction

  // the master still holds its request in the ack cycle, so a write lands at the edge where it sees ack
  assign wr_go = (wb_state_q == WB_ACK) && wb_cyc_i && wb_stb_i && wb_we_i;

  // one-wait-state ack; read data is captured when the request is taken
  always_comb begin
    wb_state_d = wb_state_q;
    ctrl_d = ctrl_q;
    aux_d = aux_q;
    period_d = period_q;
    rdat_d = rdat_q;
    ack_d = 1'b0;
    case (wb_state_q)
      WB_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          ack_d = 1'b1;
          wb_state_d = WB_ACK;
          case (wb_adr_i)
            `LEB_CTRL_OFS: begin
              rdat_d = {16'h0000, ctrl_q};
            end
            `LEB_AUX_OFS: begin
              rdat_d = {16'h0000, aux_q};
            end
            `LEB_PERIOD_OFS: begin
              rdat_d = {16'h0000, period_q};
            end
            `LEB_STATUS_OFS: begin
              rdat_d = {30'h0000_0000, prot_s};
            end
            default: begin
              rdat_d = 32'h0000_0000; // unmapped: acked, reads zero
            end
          endcase
        end
      end
      WB_ACK: begin
        wb_state_d = WB_IDLE; // ack lasts one cycle; a strobe still held when back in idle is taken as a new request
        if (wr_go) begin
          case (wb_adr_i)
            `LEB_CTRL_OFS: begin
              ctrl_d = lane_merge(ctrl_q, wb_dat_i, wb_sel_i) & `LEB_CTRL_MASK;
            end
            `LEB_AUX_OFS: begin
              aux_d = lane_merge(aux_q, wb_dat_i, wb_sel_i);
            end
            `LEB_PERIOD_OFS: begin
              period_d = lane_merge(period_q, wb_dat_i, wb_sel_i);
            end
            default: begin
              ctrl_d = ctrl_q; // status and unmapped: writes dropped
            end
          endcase
        end
      end
      default: begin
        wb_state_d = WB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_state_q <= WB_IDLE;
      ctrl_q <= `LEB_CTRL_RST;
      aux_q <= `LEB_AUX_RST;
      period_q <= `LEB_PERIOD_RST;
      rdat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      wb_state_q <= wb_state_d;
      ctrl_q <= ctrl_d;
      aux_q <= aux_d;
      period_q <= period_d;
      rdat_q <= rdat_d;
      ack_q <= ack_d;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  // ************************************
  // leading-edge trigger and counter
  // ************************************
  logic hs_prev_q;
  logic ls_prev_q;
  logic trig;
  logic leb_active;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_prev_q <= 1'b0;
      ls_prev_q <= 1'b0;
    end else begin
      hs_prev_q <= hs_s;
      ls_prev_q <= ls_s;
    end
  end

  // disabled edges never restart the count
  assign trig = (ctrl_q[`LEB_HRISE_BIT] && hs_s && !hs_prev_q)
    || (ctrl_q[`LEB_HFALL_BIT] && !hs_s && hs_prev_q)
    || (ctrl_q[`LEB_LRISE_BIT] && ls_s && !ls_prev_q)
    || (ctrl_q[`LEB_LFALL_BIT] && !ls_s && ls_prev_q);

  leb_counter u_leb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(trig),
    .period_i(period_q),
    .active_o(leb_active)
  );

  // ************************************
  // state blanking and outputs
  // ************************************
  logic sel_sig;
  logic [`LEB_NCOND-1:0] cond;
  logic state_blank;
  logic flt_blank;
  logic cl_blank;
  logic fault_q;
  logic fault_d;
  logic climit_q;
  logic climit_d;

  assign sel_sig = src_s[aux_q[`LEB_SEL_LSB +: `LEB_SEL_W]];

  // each condition only counts when its enable bit is set
  always_comb begin
    cond[5] = ctrl_q[`LEB_SIGH_BIT] && sel_sig;
    cond[4] = ctrl_q[`LEB_SIGL_BIT] && !sel_sig;
    cond[3] = ctrl_q[`LEB_HH_BIT] && hs_s;
    cond[2] = ctrl_q[`LEB_HL_BIT] && !hs_s;
    cond[1] = ctrl_q[`LEB_LH_BIT] && ls_s;
    cond[0] = ctrl_q[`LEB_LL_BIT] && !ls_s;
  end

  assign state_blank = |cond;
  assign flt_blank = state_blank || (ctrl_q[`LEB_FLT_BIT] && leb_active);
  assign cl_blank = state_blank || (ctrl_q[`LEB_CL_BIT] && leb_active);

  // registered so the outputs come straight from flops
  always_comb begin
    fault_d = flt_s && !flt_blank;
    climit_d = cl_s && !cl_blank;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
      climit_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
      climit_q <= climit_d;
    end
  end

  assign prot_s = {climit_q, fault_q};
  assign fault_o = fault_q;
  assign climit_o = climit_q;

  // ************************************
  // assertions
  // ************************************
  // a control read taken while the slave is idle
  sequence s_ctrl_read;
    (wb_state_q == WB_IDLE) && wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == `LEB_CTRL_OFS;
  endsequence

  AST_RSV_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) ctrl_q[9:6] == 4'h0)
    else $error("reserved control bits not zero");
  AST_RSV_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ctrl_read |=> wb_ack_o && wb_dat_o[9:6] == 4'h0)
    else $error("reserved bits read nonzero");
  AST_FLT_LEB: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[`LEB_FLT_BIT] && leb_active) |=> !fault_o)
    else $error("fault passed during edge blanking");
  AST_FLT_NOLEB: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl_q[`LEB_FLT_BIT] && !state_blank && flt_s) |=> fault_o)
    else $error("fault blanked without enable");
  AST_CL_LEB: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[`LEB_CL_BIT] && leb_active) |=> !climit_o)
    else $error("limit passed during edge blanking");
  AST_CL_NOLEB: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl_q[`LEB_CL_BIT] && !state_blank && cl_s) |=> climit_o)
    else $error("limit blanked without enable");
  AST_SIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[`LEB_SIGH_BIT] && sel_sig) |=> !fault_o && !climit_o)
    else $error("signal high did not blank");
  AST_SIGL: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[`LEB_SIGL_BIT] && !sel_sig) |=> !fault_o && !climit_o)
    else $error("signal low did not blank");
  AST_HH: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[`LEB_HH_BIT] && hs_s) |=> !fault_o && !climit_o)
    else $error("high side high did not blank");
  AST_HL: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[`LEB_HL_BIT] && !hs_s) |=> !fault_o && !climit_o)
    else $error("high side low did not blank");
  AST_LH: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[`LEB_LH_BIT] && ls_s) |=> !fault_o && !climit_o)
    else $error("low side high did not blank");
  AST_LL: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[`LEB_LL_BIT] && !ls_s) |=> !fault_o && !climit_o)
    else $error("low side low did not blank");
  AST_TRIG: assert property (@(posedge clk_i) disable iff (rst_i)
    (trig && period_q > 16'h0001) |=> ##1 leb_active)
    else $error("enabled edge did not restart counter");
  AST_NOTRIG: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[15:12] == 4'h0) |-> !trig)
    else $error("disabled edge restarted counter");
endmodule

// [design/sync2.sv]
// two-flop synchroniser for one pin
`timescale 1ns/1ps
module sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  logic meta_d;
  logic q_d;
  logic q_q;

  // first flop only feeds the second
  always_comb begin
    meta_d = d_i;
    q_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      q_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      q_q <= q_d;
    end
  end

  assign q_o = q_q;
endmodule

// [verif/testbench.sv]
// self-checking bench for the pwm channel blanking unit
`timescale 1ns/1ps
`include "leb_regs.svh"
module testbench;
  import leb_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic hi = 1'b0, lo = 1'b0, flt = 1'b1, cl = 1'b1;
  logic [15:0] src = 16'h0000;
  logic fault_o, climit_o;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  reg16_t rd;

  pwm_fault_limit_blanking u_pwm_fault_limit_blanking (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pwm_high_side_out_i(hi), .pwm_low_side_out_i(lo), .blank_src_i(src),
    .fault_i(flt), .climit_i(cl), .fault_o(fault_o), .climit_o(climit_o)
  );

  // ************
  // clock, timeout
  // ************
  always #12.5 clk_i = ~clk_i;
  // hang guard: whole run needs well under a few thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // ************
  // bus and pin helpers
  // ************
  // classic cycle: hold request until ack is sampled, then drop for a cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {16'h0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[15:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic pins(input logic h, input logic l, input logic [15:0] s, input int n);
    @(posedge clk_i);
    hi <= h; lo <= l; src <= s;
    repeat (n) @(posedge clk_i);
  endtask

  // expect both outputs; blanked means low while raw inputs are high
  task automatic outs(input logic f, input logic c, input string msg);
    chk({14'h0000, fault_o, climit_o}, {14'h0000, f, c}, msg);
  endtask

  // ************
  // scenarios
  // ************
  task automatic regs_test();
    wb(1'b0, `LEB_CTRL_OFS, 16'h0000);
    chk(rd, 16'h0000, "ctrl reset");
    wb(1'b1, `LEB_CTRL_OFS, 16'hFFFF);
    wb(1'b0, `LEB_CTRL_OFS, 16'h0000);
    chk(rd, 16'hFC3F, "ctrl bits 9..6 not zero");
    wb(1'b1, 4'h2, 16'hFFFF);
    wb(1'b0, 4'h2, 16'h0000);
    chk(rd, 16'h0000, "unmapped read");
    wb(1'b1, `LEB_CTRL_OFS, 16'h0000);
    repeat (6) @(posedge clk_i);
    wb(1'b0, `LEB_STATUS_OFS, 16'h0000);
    chk(rd, 16'h0003, "status unblanked");
  endtask

  // one enable at a time; bit index picks pin (low, high, source) and level
  task automatic state_test();
    logic lv;
    logic blk;
    for (int b = 0; b < 6; b++) begin
      wb(1'b1, `LEB_CTRL_OFS, 16'h0001 << b);
      for (int t = 0; t < 2; t++) begin
        lv = (t == 0) ? b[0] : ~b[0];
        blk = (t == 0);
        pins((b / 2 == 1) ? lv : 1'b0, (b / 2 == 0) ? lv : 1'b0, {15'h0000, (b / 2 == 2) ? lv : 1'b0}, 5);
        outs(~blk, ~blk, "single state condition");
      end
    end
  endtask

  task automatic any_test();
    wb(1'b1, `LEB_CTRL_OFS, 16'h0009);
    pins(1'b0, 1'b1, 16'h0000, 5);
    outs(1'b1, 1'b1, "no condition true");
    pins(1'b1, 1'b1, 16'h0000, 5);
    outs(1'b0, 1'b0, "high-side high of two");
    pins(1'b0, 1'b0, 16'h0000, 5);
    outs(1'b0, 1'b0, "low-side low of two");
  endtask

  task automatic select_test();
    wb(1'b1, `LEB_AUX_OFS, 16'h0500);
    wb(1'b1, `LEB_CTRL_OFS, 16'h0020);
    pins(1'b0, 1'b0, 16'h0020, 5);
    outs(1'b0, 1'b0, "selected source high");
    pins(1'b0, 1'b0, 16'h0001, 5);
    outs(1'b1, 1'b1, "unselected source high");
    wb(1'b1, `LEB_AUX_OFS, 16'h0000);
  endtask

  // period of 20 cycles; checks land well inside and well past the window
  task automatic edge_test();
    wb(1'b1, `LEB_CTRL_OFS, 16'h0000);
    pins(1'b0, 1'b0, 16'h0000, 4);
    wb(1'b1, `LEB_PERIOD_OFS, 16'h0014);
    wb(1'b1, `LEB_CTRL_OFS, 16'h8800);
    pins(1'b1, 1'b0, 16'h0000, 6);
    outs(1'b0, 1'b1, "fault window on high rise");
    repeat (34) @(posedge clk_i);
    outs(1'b1, 1'b1, "window ended");
    wb(1'b1, `LEB_CTRL_OFS, 16'h1400);
    pins(1'b0, 1'b0, 16'h0000, 6);
    outs(1'b1, 1'b1, "disabled high fall");
    pins(1'b0, 1'b1, 16'h0000, 6);
    outs(1'b1, 1'b1, "disabled low rise");
    pins(1'b0, 1'b0, 16'h0000, 6);
    outs(1'b1, 1'b0, "limit window on low fall");
    repeat (34) @(posedge clk_i);
  endtask

  // ************
  // main sequence
  // ************
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    regs_test();
    state_test();
    any_test();
    select_test();
    edge_test();
    complete_run();
  end
endmodule
